// ---- rtl/bfs_pkg.sv ----
package bfs_pkg;

  // Debounce and fault counter geometry.
  localparam int unsigned CNT_W        = 3;
  localparam logic [2:0]  UV_COUNT_MAX = 3'h7;
  localparam logic [2:0]  FAULT_MAX    = 3'h7;
  localparam logic [2:0]  RESTART_SS   = 3'h7;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CL = 4'h4;

  // Control register fields and reset value.
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [7:0]  CTRL_RESET   = 8'h01;

  // Interrupt bit positions.
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_PG_RISE  = 0;
  localparam int unsigned IRQ_UV       = 1;
  localparam int unsigned IRQ_OC       = 2;
  localparam int unsigned IRQ_RESTART  = 3;

  typedef enum logic [1:0] {
    BFS_OFF     = 2'b00,
    BFS_RUN     = 2'b01,
    BFS_RESTART = 2'b11
  } bfs_state_t;

  // Per-cycle observations from the oscillator, ramp and comparators.
  typedef struct packed {
    logic clk_pulse;
    logic ramp_at_90;
    logic sync_cut;
    logic oc_trip;
    logic ss_cycle_done;
  } bfs_sense_t;

  // Gate-drive and soft-start commands.
  typedef struct packed {
    logic high_side_on;
    logic low_side_gate_drive;
    logic softstart_hold_low;
    logic power_good;
  } bfs_drive_t;

endpackage : bfs_pkg

// ---- rtl/bfs_sequencer.sv ----
// How it works
// - Soft-start held low while supply is low.
// - Clock before ramp reaches 90% is undervoltage.
// - Seven good cycles assert power-good, start.
// - Seven bad cycles after start declare undervoltage.
// - Overcurrent sensed only while high side on.
// - Overcurrent ends high pulse until next cycle.
// - Fault counter up on trip, down otherwise.
// - At seven, both off, seven soft-starts.
// - Count down per soft-start, resume at zero.
// - Sync-shortened ramp counts as undervoltage.
`timescale 1ns/1ps
`default_nettype none
module bfs_sequencer (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Sense inputs, synchronous to sys_clk.
  input  wire bfs_pkg::bfs_sense_t sense,
  input  wire logic               pwm_request,
  // Gate drive and soft-start outputs.
  output var  bfs_pkg::bfs_drive_t drive,
  output logic                    irq,
  // Register port.
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata
);

  bfs_pkg::bfs_state_t state_reg, state_next;
  logic [2:0] uv_cnt_reg, uv_cnt_next;
  logic [2:0] flt_cnt_reg, flt_cnt_next;
  logic       uv_reg, uv_next;
  logic       oc_latch_reg, oc_latch_next;
  logic       oc_cycle_reg, oc_cycle_next;
  bfs_pkg::bfs_drive_t drive_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [3:0] ist_reg, ist_next, ien_reg, ien_next;
  logic [7:0] rdata_next;
  logic       irq_next;
  logic       bad_cycle, good_cycle, oc_hit, run_en;
  logic [3:0] events;

  function automatic logic sel(input logic [3:0] a, input logic [3:0] off);
    sel = (a == off);
  endfunction : sel

  // A cycle is bad when the clock beats the ramp to 90% or sync cuts it short.
  assign bad_cycle  = sense.clk_pulse & (~sense.ramp_at_90 | sense.sync_cut);
  assign good_cycle = sense.clk_pulse & sense.ramp_at_90 & ~sense.sync_cut;
  // The comparator is ignored unless the high side is being driven.
  assign oc_hit = sense.oc_trip & drive.high_side_on;
  assign run_en = ctrl_reg[bfs_pkg::CTRL_RUN_BIT];

  always_comb begin
    state_next    = state_reg;
    uv_cnt_next   = uv_cnt_reg;
    flt_cnt_next  = flt_cnt_reg;
    uv_next       = uv_reg;
    oc_latch_next = oc_latch_reg;
    oc_cycle_next = oc_cycle_reg | oc_hit;
    events        = 4'h0;
    // Undervoltage debounce: count toward the opposite verdict, reset on agreement.
    if (uv_reg) begin
      if (good_cycle) begin
        uv_cnt_next = uv_cnt_reg + 3'h1;
        if (uv_cnt_reg == bfs_pkg::UV_COUNT_MAX - 3'h1) begin
          uv_next     = 1'b0;
          uv_cnt_next = 3'h0;
          events[bfs_pkg::IRQ_PG_RISE] = 1'b1;
        end
      end else if (bad_cycle) begin
        uv_cnt_next = 3'h0;
      end
    end else begin
      if (bad_cycle) begin
        uv_cnt_next = uv_cnt_reg + 3'h1;
        if (uv_cnt_reg == bfs_pkg::UV_COUNT_MAX - 3'h1) begin
          uv_next     = 1'b1;
          uv_cnt_next = 3'h0;
          events[bfs_pkg::IRQ_UV] = 1'b1;
        end
      end else if (good_cycle) begin
        uv_cnt_next = 3'h0;
      end
    end
    // Pulse-by-pulse limit: latched until the next cycle starts.
    if (oc_hit) begin
      oc_latch_next = 1'b1;
      events[bfs_pkg::IRQ_OC] = 1'b1;
    end else if (sense.clk_pulse) begin
      oc_latch_next = 1'b0;
    end
    case (state_reg)
      bfs_pkg::BFS_OFF: begin
        flt_cnt_next = 3'h0;
        if (!uv_next && run_en) begin
          state_next = bfs_pkg::BFS_RUN;
        end
      end
      bfs_pkg::BFS_RUN: begin
        if (sense.clk_pulse) begin
          oc_cycle_next = 1'b0;
          // Saturating count keeps a long overload from wrapping past seven.
          if (oc_cycle_reg | oc_hit) begin
            if (flt_cnt_reg != bfs_pkg::FAULT_MAX) begin
              flt_cnt_next = flt_cnt_reg + 3'h1;
            end
          end else if (flt_cnt_reg != 3'h0) begin
            flt_cnt_next = flt_cnt_reg - 3'h1;
          end
          if ((oc_cycle_reg | oc_hit) && flt_cnt_reg == bfs_pkg::FAULT_MAX - 3'h1) begin
            state_next   = bfs_pkg::BFS_RESTART;
            flt_cnt_next = bfs_pkg::RESTART_SS;
            events[bfs_pkg::IRQ_RESTART] = 1'b1;
          end
        end
        if (uv_next || !run_en) begin
          state_next = bfs_pkg::BFS_OFF;
        end
      end
      bfs_pkg::BFS_RESTART: begin
        oc_cycle_next = 1'b0;
        if (sense.ss_cycle_done) begin
          flt_cnt_next = flt_cnt_reg - 3'h1;
          if (flt_cnt_reg == 3'h1) begin
            state_next = bfs_pkg::BFS_RUN;
          end
        end
        if (uv_next || !run_en) begin
          state_next = bfs_pkg::BFS_OFF;
        end
      end
      default: begin
        state_next = bfs_pkg::BFS_OFF;
      end
    endcase
  end

  always_comb begin
    drive_next.power_good          = ~uv_next;
    // Restart also needs the soft-start node cycling, so hold is undervoltage or run bit cleared only.
    drive_next.softstart_hold_low  = uv_next | ~run_en;
    drive_next.high_side_on        = (state_next == bfs_pkg::BFS_RUN) & pwm_request
                                     & ~oc_latch_next;
    drive_next.low_side_gate_drive = (state_next == bfs_pkg::BFS_RUN) & ~pwm_request;
  end

  always_comb begin
    ctrl_next  = ctrl_reg;
    ien_next   = ien_reg;
    ist_next   = ist_reg;
    rdata_next = 8'h00;
    if (reg_wr && sel(reg_addr, bfs_pkg::ADDR_CTRL)) begin
      ctrl_next = reg_wdata;
    end
    if (reg_wr && sel(reg_addr, bfs_pkg::ADDR_IRQ_EN)) begin
      ien_next = reg_wdata[3:0];
    end
    if (reg_wr && sel(reg_addr, bfs_pkg::ADDR_IRQ_CL)) begin
      ist_next = ist_reg & ~reg_wdata[3:0];
    end
    // Set after clear so a simultaneous event survives the clear.
    ist_next = ist_next | events;
    if (reg_rd) begin
      case (reg_addr)
        bfs_pkg::ADDR_CTRL:   rdata_next = ctrl_reg;
        bfs_pkg::ADDR_STATUS: rdata_next = {flt_cnt_reg, uv_reg, oc_latch_reg,
                                            drive.power_good, state_reg};
        bfs_pkg::ADDR_IRQ_ST: rdata_next = {4'h0, ist_reg};
        bfs_pkg::ADDR_IRQ_EN: rdata_next = {4'h0, ien_reg};
        default:              rdata_next = 8'h00;
      endcase
    end
    irq_next = |(ist_next & ien_next);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= bfs_pkg::BFS_OFF;
      uv_cnt_reg   <= 3'h0;
      flt_cnt_reg  <= 3'h0;
      uv_reg       <= 1'b1;
      oc_latch_reg <= 1'b0;
      oc_cycle_reg <= 1'b0;
      drive        <= '{high_side_on: 1'b0, low_side_gate_drive: 1'b0,
                        softstart_hold_low: 1'b1, power_good: 1'b0};
      ctrl_reg     <= bfs_pkg::CTRL_RESET;
      ist_reg      <= 4'h0;
      ien_reg      <= 4'h0;
      reg_rdata    <= 8'h00;
      irq          <= 1'b0;
    end else begin
      state_reg    <= state_next;
      uv_cnt_reg   <= uv_cnt_next;
      flt_cnt_reg  <= flt_cnt_next;
      uv_reg       <= uv_next;
      oc_latch_reg <= oc_latch_next;
      oc_cycle_reg <= oc_cycle_next;
      drive        <= drive_next;
      ctrl_reg     <= ctrl_next;
      ist_reg      <= ist_next;
      ien_reg      <= ien_next;
      reg_rdata    <= rdata_next;
      irq          <= irq_next;
    end
  end

  // Drive is registered from the same next values as state_reg and uv_reg, so these
  // checks line them up in one cycle; an offset of one would misfire on restart exit.
  chk_hold_while_uv: assert property (@(posedge sys_clk) disable iff (!nrst)
    uv_reg |-> drive.softstart_hold_low)
    else $error("soft-start released in undervoltage");

  chk_uv_gates_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    uv_reg |-> !drive.high_side_on && !drive.low_side_gate_drive)
    else $error("switch on in undervoltage");

  chk_bad_cycle_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!uv_reg && sense.clk_pulse && !sense.ramp_at_90 && uv_cnt_reg == 3'h2)
    |=> uv_cnt_reg == 3'h3)
    else $error("short ramp not counted");

  chk_short_ramp_bad: assert property (@(posedge sys_clk) disable iff (!nrst)
    (uv_reg && sense.clk_pulse && !sense.ramp_at_90) |=> uv_reg && uv_cnt_reg == 3'h0)
    else $error("short ramp counted as good");

  chk_pg_after_seven: assert property (@(posedge sys_clk) disable iff (!nrst)
    $fell(uv_reg) |-> $past(uv_cnt_reg) == 3'h6 ##1 drive.power_good)
    else $error("power-good without seven good cycles");

  chk_pg_mirrors_uv: assert property (@(posedge sys_clk) disable iff (!nrst)
    drive.power_good != uv_reg)
    else $error("power-good disagrees with undervoltage verdict");

  chk_uv_after_seven: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(uv_reg) |-> $past(uv_cnt_reg) == 3'h6 ##1 !drive.power_good)
    else $error("undervoltage without seven bad cycles");

  chk_good_clears_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!uv_reg && sense.clk_pulse && sense.ramp_at_90 && !sense.sync_cut)
    |=> uv_cnt_reg == 3'h0)
    else $error("good cycle did not restart the bad count");

  chk_sync_is_uv: assert property (@(posedge sys_clk) disable iff (!nrst)
    (uv_reg && sense.clk_pulse && sense.sync_cut) |=> uv_cnt_reg == 3'h0)
    else $error("sync cut counted as good");

  chk_sync_counts_bad: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!uv_reg && sense.clk_pulse && sense.sync_cut && uv_cnt_reg == 3'h0)
    |=> uv_cnt_reg == 3'h1)
    else $error("sync cut not counted as bad");

  chk_oc_ignored_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!drive.high_side_on && sense.oc_trip && !oc_latch_reg) |=> !oc_latch_reg)
    else $error("overcurrent taken while high side off");

  chk_oc_ends_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
    (drive.high_side_on && sense.oc_trip && !sense.clk_pulse) |=> !drive.high_side_on)
    else $error("high side not ended by overcurrent");

  chk_oc_holds_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (oc_latch_reg && !sense.clk_pulse) |=> !drive.high_side_on)
    else $error("high side back on before next cycle");

  chk_fault_count_up: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == bfs_pkg::BFS_RUN && sense.clk_pulse && oc_cycle_reg
     && flt_cnt_reg < 3'h6) |=> flt_cnt_reg == $past(flt_cnt_reg) + 3'h1)
    else $error("fault counter not incremented");

  chk_fault_count_down: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == bfs_pkg::BFS_RUN && sense.clk_pulse && !oc_cycle_reg && !oc_hit
     && flt_cnt_reg != 3'h0) |=> flt_cnt_reg == $past(flt_cnt_reg) - 3'h1)
    else $error("fault counter not decremented");

  chk_restart_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == bfs_pkg::BFS_RUN && sense.clk_pulse && oc_cycle_reg
     && flt_cnt_reg == 3'h6 && !uv_next && run_en) |=> state_reg == bfs_pkg::BFS_RESTART)
    else $error("seventh fault did not restart");

  chk_restart_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(state_reg == bfs_pkg::BFS_RESTART) |-> flt_cnt_reg == 3'h7)
    else $error("restart without seven faults");

  chk_restart_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == bfs_pkg::BFS_RESTART) |-> !drive.high_side_on && !drive.low_side_gate_drive)
    else $error("switch on during restart");

  chk_restart_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == bfs_pkg::BFS_RESTART && !sense.ss_cycle_done && !uv_next && run_en)
    |=> state_reg == bfs_pkg::BFS_RESTART) else $error("restart left early");

  chk_restart_step: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == bfs_pkg::BFS_RESTART && sense.ss_cycle_done)
    |=> flt_cnt_reg == $past(flt_cnt_reg) - 3'h1) else $error("restart count not stepped");

  chk_restart_exit: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($past(state_reg) == bfs_pkg::BFS_RESTART && state_reg == bfs_pkg::BFS_RUN)
    |-> flt_cnt_reg == 3'h0) else $error("pwm resumed with nonzero count");

endmodule : bfs_sequencer
`default_nettype wire

// ---- test/bfs_sense_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bfs_sense_model #(
  parameter int PERIOD = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                supply_ok,
  input  wire logic                overload,
  input  wire logic                sync_on,
  output var  bfs_pkg::bfs_sense_t sense
);
  int   cnt;
  logic pulse;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt   <= 0;
      pulse <= 1'b0;
    end else begin
      cnt   <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      pulse <= (cnt == PERIOD - 1);
    end
  end
  // The comparator runs free, so gating it by the gate state is the block's job.
  always_comb begin
    sense.clk_pulse     = pulse;
    sense.ramp_at_90    = supply_ok;
    sense.sync_cut      = pulse & sync_on;
    sense.oc_trip       = overload;
    sense.ss_cycle_done = pulse;
  end
endmodule : bfs_sense_model
`default_nettype wire

// ---- test/tb_bfs_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_bfs_sequencer;
  logic                sys_clk, nrst, pwm_request, irq, reg_wr, reg_rd;
  logic                supply_ok, overload, sync_on;
  bfs_pkg::bfs_sense_t sense;
  bfs_pkg::bfs_drive_t drive;
  logic [3:0]          reg_addr;
  logic [7:0]          reg_wdata, reg_rdata, v;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  i;

  bfs_sense_model i_far (.sys_clk(sys_clk), .nrst(nrst), .supply_ok(supply_ok),
    .overload(overload), .sync_on(sync_on), .sense(sense));
  bfs_sequencer i_dut (.sys_clk(sys_clk), .nrst(nrst), .sense(sense),
    .pwm_request(pwm_request), .drive(drive), .irq(irq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic pulses(input int n);
    repeat (n) @(posedge sys_clk iff sense.clk_pulse);
    #1;
  endtask : pulses
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_reset(input logic in_rst);
    chk({4'h0, drive}, 8'h02);
    chk({7'h0, irq}, 8'h00);
    if (in_rst) begin
      chk(reg_rdata, 8'h00);
    end else begin
      rd(bfs_pkg::ADDR_CTRL);
      chk(v, bfs_pkg::CTRL_RESET);
      rd(bfs_pkg::ADDR_STATUS);
      chk(v, 8'h10);
    end
  endtask : t_reset
  task automatic t_powerup;
    supply_ok <= 1'b1;
    pulses(6);
    chk({6'h0, drive.power_good, drive.softstart_hold_low}, 8'h01);
    pulses(1);
    tick(2);
    chk({6'h0, drive.power_good, drive.softstart_hold_low}, 8'h02);
  endtask : t_powerup
  task automatic t_irq;
    rd(bfs_pkg::ADDR_IRQ_ST);
    chk({7'h0, v[0]}, 8'h01);
    wr(bfs_pkg::ADDR_IRQ_EN, 8'h01);
    tick(2);
    chk({7'h0, irq}, 8'h01);
    wr(bfs_pkg::ADDR_IRQ_CL, 8'h01);
    tick(2);
    chk({7'h0, irq}, 8'h00);
    rd(4'hF);
    chk(v, 8'h00);
    wr(bfs_pkg::ADDR_IRQ_EN, 8'h08);
  endtask : t_irq
  task automatic t_oc;
    overload <= 1'b1;
    pulses(3);
    rd(bfs_pkg::ADDR_STATUS);
    chk({4'h0, v[7:5], v[3]}, 8'h00);
    pwm_request <= 1'b1;
    for (i = 0; i < 40 && drive.high_side_on !== 1'b1; i++) tick(1);
    tick(2);
    chk({7'h0, drive.high_side_on}, 8'h00);
    for (i = 0; i < 8 && sense.clk_pulse !== 1'b1; i++) begin
      chk({7'h0, drive.high_side_on}, 8'h00);
      tick(1);
    end
    tick(1);
    chk({7'h0, drive.high_side_on}, 8'h01);
    rd(bfs_pkg::ADDR_STATUS);
    chk({5'h0, v[7:5]}, 8'h01);
    for (i = 0; i < 60 && v[1:0] !== 2'b11; i++) rd(bfs_pkg::ADDR_STATUS);
    chk({6'h0, v[1:0]}, 8'h03);
    tick(3);
    chk({6'h0, drive.high_side_on, drive.low_side_gate_drive}, 8'h00);
    chk({7'h0, irq}, 8'h01);
    overload <= 1'b0;
    pulses(6);
    rd(bfs_pkg::ADDR_STATUS);
    chk({6'h0, v[1:0]}, 8'h03);
    pulses(1);
    tick(2);
    rd(bfs_pkg::ADDR_STATUS);
    chk({3'h0, v[7:5], v[1:0]}, 8'h01);
    overload <= 1'b1;
    pulses(1);
    overload <= 1'b0;
    rd(bfs_pkg::ADDR_STATUS);
    chk({5'h0, v[7:5]}, 8'h01);
    pulses(1);
    rd(bfs_pkg::ADDR_STATUS);
    chk({5'h0, v[7:5]}, 8'h00);
    wr(bfs_pkg::ADDR_IRQ_CL, 8'h0F);
  endtask : t_oc
  task automatic t_uv;
    supply_ok <= 1'b0;
    pulses(6);
    chk({7'h0, drive.power_good}, 8'h01);
    pulses(2);
    tick(2);
    chk({6'h0, drive.power_good, drive.softstart_hold_low}, 8'h01);
    supply_ok <= 1'b1;
    pulses(9);
    sync_on <= 1'b1;
    pulses(6);
    chk({7'h0, drive.power_good}, 8'h01);
    pulses(2);
    tick(2);
    chk({7'h0, drive.power_good}, 8'h00);
  endtask : t_uv

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Bound is about fourteen times the expected run of roughly 430 cycles.
  initial begin
    repeat (6000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {nrst, pwm_request, reg_wr, reg_rd, supply_ok, overload, sync_on} = 7'h00;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    t_reset(1'b1);
    @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    t_reset(1'b0);
    t_powerup();
    t_irq();
    t_oc();
    t_uv();
    report_and_stop();
  end
endmodule : tb_bfs_sequencer
`default_nettype wire
